/* design/adcs_device.sv */
// Conversion sequencer: trigger handling, SAR decisions, parallel and serial output
`timescale 1ns/1ps
module adcs_device #(
  parameter bit EXT_TEMP = 1'b0
) (
  // Converter clock, shared with the link
  input wire logic link_clk,
  // Link to the host
  adcs_link_if.dev link,
  // Comparator and DAC trial word, same clock
  input wire logic comp_decision,
  output logic [adcs_pkg::RES_BITS-1:0] trial_word,
  // Coding straps, asynchronous
  input wire logic bipolar_mode,
  input wire logic twos_comp_sel,
  // Status
  output logic conv_late
);

  localparam int GAP_CYC = EXT_TEMP ? adcs_pkg::STROBE_GAP_EXT_CYC
                                    : adcs_pkg::STROBE_GAP_CYC;
  localparam int LATE_CYC = EXT_TEMP ? adcs_pkg::CONV_EXT_CYC : adcs_pkg::CONV_CYC;
  localparam logic [adcs_pkg::CNT_W-1:0] GAP_LAST = adcs_pkg::CNT_W'(GAP_CYC - 1);
  localparam logic [adcs_pkg::CNT_W-1:0] LATE_LIM = adcs_pkg::CNT_W'(LATE_CYC);
  localparam logic [adcs_pkg::IDX_W-1:0] LAST_SLOT = adcs_pkg::IDX_W'(adcs_pkg::RES_BITS);
  localparam logic [adcs_pkg::IDX_W-1:0] MSB_POS = adcs_pkg::IDX_W'(adcs_pkg::RES_BITS - 1);
  localparam logic [adcs_pkg::RES_BITS-1:0] MSB_TRIAL = {1'b1, {(adcs_pkg::RES_BITS-1){1'b0}}};

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic trig_s1;
  logic trig_s2;
  logic bip_s1;
  logic bip_s2;
  logic tc_s1;
  logic tc_s2;

  // Trigger and straps come from other clocks or pins
  always_ff @(posedge link_clk) begin
    trig_s1 <= link.trigger;
    trig_s2 <= trig_s1;
    bip_s1 <= bipolar_mode;
    bip_s2 <= bip_s1;
    tc_s1 <= twos_comp_sel;
    tc_s2 <= tc_s1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  adcs_pkg::adcs_dev_state_t state;
  adcs_pkg::adcs_dev_state_t next_state;
  logic [adcs_pkg::CNT_W-1:0] span;
  logic [adcs_pkg::CNT_W-1:0] next_span;
  logic [adcs_pkg::CNT_W-1:0] gap_cnt;
  logic [adcs_pkg::CNT_W-1:0] next_gap_cnt;
  logic [adcs_pkg::CNT_W-1:0] late_cnt;
  logic [adcs_pkg::CNT_W-1:0] next_late_cnt;
  logic [adcs_pkg::IDX_W-1:0] slot;
  logic [adcs_pkg::IDX_W-1:0] next_slot;
  logic [adcs_pkg::IDX_W-1:0] pos;
  logic [adcs_pkg::RES_BITS-1:0] code;
  logic [adcs_pkg::RES_BITS-1:0] next_code;
  logic [adcs_pkg::RES_BITS-1:0] next_trial;
  logic [adcs_pkg::WORD_BITS-1:0] next_par;
  logic next_valid;
  logic next_strobe;
  logic next_ser;
  logic next_late;
  logic take;
  logic msb_par;

  // Next-state and output computation
  always_comb begin
    next_state = state;
    next_span = span;
    next_gap_cnt = gap_cnt;
    next_late_cnt = late_cnt;
    next_slot = slot;
    next_code = code;
    next_trial = trial_word;
    next_par = link.par_word;
    next_valid = link.result_valid;
    next_strobe = link.bit_strobe;
    next_ser = link.ser_data;
    next_late = conv_late;
    take = 1'b0;
    pos = '0;
    msb_par = 1'b0;
    if (trig_s2) begin
      // Trigger high holds the sequencer in reset; the parallel word keeps its last value
      next_state = adcs_pkg::ST_RESET;
      next_valid = 1'b1;
      next_strobe = 1'b0;
      next_ser = 1'b0;
      next_slot = '0;
      next_code = '0;
      next_trial = MSB_TRIAL;
      next_gap_cnt = '0;
      next_late_cnt = '0;
      next_late = 1'b0;
      // Trigger width measured for the set-up interval
      // Unknown count at power-up lands in the last branch and starts at one
      if (state == adcs_pkg::ST_RESET && span == adcs_pkg::CNT_MAX) begin
        next_span = span;
      end else if (state == adcs_pkg::ST_RESET && span != adcs_pkg::CNT_MAX) begin
        next_span = span + 8'h01;
      end else begin
        next_span = 8'h01;
      end
    end else begin
      // Count link cycles since conversion start, saturating
      if (state != adcs_pkg::ST_DONE && late_cnt != adcs_pkg::CNT_MAX) begin
        next_late_cnt = late_cnt + 8'h01;
      end
      case (state)
        adcs_pkg::ST_RESET: begin
          // Trigger fell: conversion starts
          next_state = adcs_pkg::ST_SETUP;
        end
        adcs_pkg::ST_SETUP: begin
          // Set-up lasts as many cycles as trigger stood high
          if (span <= 8'h01) begin
            next_state = adcs_pkg::ST_BIT_HI;
            next_gap_cnt = '0;
            take = 1'b1;
          end else begin
            next_span = span - 8'h01;
          end
        end
        adcs_pkg::ST_BIT_HI: begin
          // Strobe high half of the bit
          if (gap_cnt >= GAP_LAST) begin
            next_state = adcs_pkg::ST_BIT_LO;
            next_gap_cnt = '0;
          end else begin
            next_gap_cnt = gap_cnt + 8'h01;
          end
        end
        adcs_pkg::ST_BIT_LO: begin
          // Strobe low half; data still stands for the falling edge
          if (gap_cnt < GAP_LAST) begin
            next_gap_cnt = gap_cnt + 8'h01;
          end else if (slot == LAST_SLOT) begin
            next_state = adcs_pkg::ST_DONE;
            next_valid = 1'b0;
            // Two's complement flips the parallel MSB and its complemented copy, not the serial bits
            msb_par = code[adcs_pkg::RES_BITS-1] ^ (bip_s2 & tc_s2);
            // Complemented MSB sits above the ten result bits
            next_par = {~msb_par, msb_par, code[adcs_pkg::RES_BITS-2:0]};
          end else begin
            next_state = adcs_pkg::ST_BIT_HI;
            next_gap_cnt = '0;
            next_slot = slot + 4'h1;
            take = 1'b1;
          end
        end
        adcs_pkg::ST_DONE: begin
          next_strobe = 1'b0;
        end
        default: begin
          next_state = adcs_pkg::ST_RESET;
          next_valid = 1'b1;
        end
      endcase
      // Strobe high only in the first half of each bit
      next_strobe = (next_state == adcs_pkg::ST_BIT_HI);
      if (take) begin
        if (next_slot < LAST_SLOT) begin
          // One comparator decision per bit, MSB first
          pos = MSB_POS - next_slot;
          // Decision high means input beyond trial: inverted coding
          next_code[pos] = comp_decision;
          next_ser = comp_decision;
          next_trial = next_code;
          if (pos != 4'h0) begin
            next_trial[pos - 4'h1] = 1'b1;
          end
        end else begin
          // Last serial slot carries the plain complemented MSB
          next_ser = ~code[adcs_pkg::RES_BITS-1];
        end
      end
      // Flag a conversion slower than the rated time
      if (late_cnt >= LATE_LIM && state != adcs_pkg::ST_DONE) begin
        next_late = 1'b1;
      end
    end
  end

  // Registers of the sequencer; trigger acts as the only reset
  always_ff @(posedge link_clk) begin
    state <= next_state;
    span <= next_span;
    gap_cnt <= next_gap_cnt;
    late_cnt <= next_late_cnt;
    slot <= next_slot;
    code <= next_code;
    trial_word <= next_trial;
    link.par_word <= next_par;
    link.result_valid <= next_valid;
    link.bit_strobe <= next_strobe;
    link.ser_data <= next_ser;
    conv_late <= next_late;
  end

endmodule

/* include/adcs_pkg.sv */
// Shared constants and types for the conversion sequencer and its host
//
// Summary of operation
// - Trigger high resets; trigger low starts conversion
// - Result-valid high in reset and conversion
// - Conversion finishes within 800 ns; here over 22 link cycles of 160 ns, flagged by conv_late
// - Host captures parallel word on valid fall
// - Timing holds with trigger no wider 70ns
// - Serial NRZ, MSB first, one strobe each
// - Eleven bits: ten plus complemented MSB
// - Coding inverted; binary or offset binary
// - Two's complement on parallel output only
// - Strobe spacing 45 ns, extended part 55; here one 160 ns link cycle for both
// - Host takes serial bit on strobe fall
// - Host delays strobe 15 to 20 ns; here one 25 ns host cycle
// - Trigger width sets first set-up interval
package adcs_pkg;

  // Word layout
  localparam int RES_BITS = 10;
  localparam int WORD_BITS = 11;
  localparam int IDX_W = 4;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;

  // Clock periods in ns
  localparam int CLK_PERIOD_NS = 25;
  localparam int LINK_PERIOD_NS = 160;

  // Documented times in ns
  localparam int CONV_MAX_NS = 800;
  localparam int CONV_MAX_EXT_NS = 900;
  localparam int TRIG_REF_NS = 45;
  localparam int TRIG_MAX_NS = 70;
  localparam int STROBE_GAP_NS = 45;
  localparam int STROBE_GAP_EXT_NS = 55;
  localparam int STROBE_DLY_MIN_NS = 15;
  localparam int STROBE_DLY_MAX_NS = 20;

  // Host-clock counts: least times round up, longest round down
  localparam int TRIG_CYC = (TRIG_REF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIG_MAX_CYC = (TRIG_MAX_NS / CLK_PERIOD_NS < 1) ? 1
                                : TRIG_MAX_NS / CLK_PERIOD_NS;
  localparam int STROBE_DLY_CYC = (STROBE_DLY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Link-clock counts, never below one cycle
  localparam int STROBE_GAP_CYC = (STROBE_GAP_NS / LINK_PERIOD_NS < 1) ? 1
                                  : STROBE_GAP_NS / LINK_PERIOD_NS;
  localparam int STROBE_GAP_EXT_CYC = (STROBE_GAP_EXT_NS / LINK_PERIOD_NS < 1) ? 1
                                      : STROBE_GAP_EXT_NS / LINK_PERIOD_NS;
  localparam int CONV_CYC = (CONV_MAX_NS / LINK_PERIOD_NS < 1) ? 1
                            : CONV_MAX_NS / LINK_PERIOD_NS;
  localparam int CONV_EXT_CYC = (CONV_MAX_EXT_NS / LINK_PERIOD_NS < 1) ? 1
                                : CONV_MAX_EXT_NS / LINK_PERIOD_NS;

  // Device sequencer states
  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_SETUP = 3'h1,
    ST_BIT_HI = 3'h2,
    ST_BIT_LO = 3'h3,
    ST_DONE = 3'h4
  } adcs_dev_state_t;

  // Host sequencer states
  typedef enum logic [1:0] {
    HS_TRIG = 2'h0,
    HS_CONV = 2'h1,
    HS_IDLE = 2'h2
  } adcs_host_state_t;

endpackage

/* include/adcs_link_if.sv */
// Link between the conversion sequencer and its host
`timescale 1ns/1ps
interface adcs_link_if;
  logic trigger;
  logic result_valid;
  logic [adcs_pkg::WORD_BITS-1:0] par_word;
  logic ser_data;
  logic bit_strobe;

  modport dev (
    input trigger,
    output result_valid,
    output par_word,
    output ser_data,
    output bit_strobe
  );

  modport host (
    output trigger,
    input result_valid,
    input par_word,
    input ser_data,
    input bit_strobe
  );
endinterface

/* design/adcs_host.sv */
// Host end: issues conversion triggers, captures parallel and serial results
`timescale 1ns/1ps
module adcs_host #(
  parameter int TRIG_HOLD = adcs_pkg::TRIG_CYC,
  parameter int STROBE_DLY = adcs_pkg::STROBE_DLY_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Link to the converter
  adcs_link_if.host link,
  // User request
  input wire logic start,
  output logic busy,
  // Results
  output logic [adcs_pkg::WORD_BITS-1:0] par_result,
  output logic par_ready,
  output logic [adcs_pkg::WORD_BITS-1:0] ser_result,
  output logic ser_ready
);

  localparam logic [adcs_pkg::CNT_W-1:0] HOLD_LAST = adcs_pkg::CNT_W'(TRIG_HOLD - 1);
  localparam logic [adcs_pkg::IDX_W-1:0] SER_LAST = adcs_pkg::IDX_W'(adcs_pkg::WORD_BITS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers and strobe delay

  logic rv_s1;
  logic rv_s2;
  logic rv_d;
  logic st_s1;
  logic st_s2;
  logic sd_s1;
  logic sd_s2;
  logic [adcs_pkg::WORD_BITS-1:0] par_s1;
  logic [adcs_pkg::WORD_BITS-1:0] par_s2;
  logic [STROBE_DLY:0] st_dly;

  // Link signals come from the converter clock
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rv_s1 <= 1'b1;
      rv_s2 <= 1'b1;
      rv_d <= 1'b1;
      st_s1 <= 1'b0;
      st_s2 <= 1'b0;
      sd_s1 <= 1'b0;
      sd_s2 <= 1'b0;
      par_s1 <= '0;
      par_s2 <= '0;
      st_dly <= '0;
    end else begin
      rv_s1 <= link.result_valid;
      rv_s2 <= rv_s1;
      rv_d <= rv_s2;
      st_s1 <= link.bit_strobe;
      st_s2 <= st_s1;
      sd_s1 <= link.ser_data;
      sd_s2 <= sd_s1;
      // Word goes two flops deep, reaching par_s2 in the same cycle the synced valid fall is seen
      par_s1 <= link.par_word;
      par_s2 <= par_s1;
      // Strobe lags data so the serial line has settled
      st_dly <= {st_dly[STROBE_DLY-1:0], st_s2};
    end
  end

  logic rv_fall;
  logic st_fall;
  assign rv_fall = rv_d & ~rv_s2;
  assign st_fall = st_dly[STROBE_DLY] & ~st_dly[STROBE_DLY-1];

  ////////////////////////////////////////////////////////////////////////////
  // Trigger sequencer and result capture

  adcs_pkg::adcs_host_state_t state;
  adcs_pkg::adcs_host_state_t next_state;
  logic [adcs_pkg::CNT_W-1:0] hold_cnt;
  logic [adcs_pkg::CNT_W-1:0] next_hold_cnt;
  logic [adcs_pkg::WORD_BITS-1:0] shift;
  logic [adcs_pkg::WORD_BITS-1:0] next_shift;
  logic [adcs_pkg::IDX_W-1:0] ser_cnt;
  logic [adcs_pkg::IDX_W-1:0] next_ser_cnt;
  logic [adcs_pkg::WORD_BITS-1:0] next_par_result;
  logic [adcs_pkg::WORD_BITS-1:0] next_ser_result;
  logic next_par_ready;
  logic next_ser_ready;
  logic next_trigger;

  // Next values of the host sequencer
  always_comb begin
    next_state = state;
    next_hold_cnt = hold_cnt;
    next_shift = shift;
    next_ser_cnt = ser_cnt;
    next_par_result = par_result;
    next_ser_result = ser_result;
    next_par_ready = 1'b0;
    next_ser_ready = 1'b0;
    next_trigger = link.trigger;
    case (state)
      adcs_pkg::HS_TRIG: begin
        // Trigger high resets the converter; pulse kept narrow
        next_trigger = 1'b1;
        next_ser_cnt = '0;
        if (hold_cnt >= HOLD_LAST) begin
          next_trigger = 1'b0;
          next_state = adcs_pkg::HS_CONV;
        end else begin
          next_hold_cnt = hold_cnt + 8'h01;
        end
      end
      adcs_pkg::HS_CONV: begin
        // Falling valid strobes the parallel word
        if (rv_fall) begin
          next_par_result = par_s2;
          next_par_ready = 1'b1;
          next_state = adcs_pkg::HS_IDLE;
        end
      end
      adcs_pkg::HS_IDLE: begin
        // New trigger only once the last result is captured
        if (start) begin
          next_state = adcs_pkg::HS_TRIG;
          next_hold_cnt = '0;
          next_trigger = 1'b1;
        end
      end
      default: begin
        next_state = adcs_pkg::HS_IDLE;
        next_trigger = 1'b0;
      end
    endcase
    // Serial bit taken on the trailing edge of its strobe
    if (st_fall && state == adcs_pkg::HS_CONV) begin
      next_shift = {shift[adcs_pkg::WORD_BITS-2:0], sd_s2};
      if (ser_cnt == SER_LAST) begin
        next_ser_result = {shift[adcs_pkg::WORD_BITS-2:0], sd_s2};
        next_ser_ready = 1'b1;
        next_ser_cnt = '0;
      end else begin
        next_ser_cnt = ser_cnt + 4'h1;
      end
    end
  end

  // Registers of the host sequencer; reset starts a first conversion
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= adcs_pkg::HS_TRIG;
      hold_cnt <= '0;
      shift <= '0;
      ser_cnt <= '0;
      par_result <= '0;
      ser_result <= '0;
      par_ready <= 1'b0;
      ser_ready <= 1'b0;
      link.trigger <= 1'b1;
    end else begin
      state <= next_state;
      hold_cnt <= next_hold_cnt;
      shift <= next_shift;
      ser_cnt <= next_ser_cnt;
      par_result <= next_par_result;
      ser_result <= next_ser_result;
      par_ready <= next_par_ready;
      ser_ready <= next_ser_ready;
      link.trigger <= next_trigger;
    end
  end

  assign busy = (state != adcs_pkg::HS_IDLE);

endmodule

/* tb/adcs_link_monitor.sv */
// Link checker: reset levels, strobe framing, serial and parallel agreement
`timescale 1ns/1ps
module adcs_link_monitor (
  // Converter clock
  input wire logic link_clk,
  // Link signals
  input wire logic trigger,
  input wire logic result_valid,
  input wire logic [adcs_pkg::WORD_BITS-1:0] par_word,
  input wire logic ser_data,
  input wire logic bit_strobe
);
  logic strobe_q, trig_q, rise;
  logic next_strobe_q, next_trig_q;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] hi_cnt, next_hi_cnt, lo_cnt, next_lo_cnt;
  logic [10:0] ser_sh, next_ser_sh;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger high restarts every count, so an aborted frame never leaks in
  always_comb begin
    rise = bit_strobe && !strobe_q;
    next_strobe_q = bit_strobe;
    next_trig_q = trigger;
    next_bit_cnt = bit_cnt;
    next_hi_cnt = hi_cnt;
    next_lo_cnt = lo_cnt;
    next_ser_sh = rise ? {ser_sh[9:0], ser_data} : ser_sh;
    if (trigger) begin
      next_bit_cnt = 4'h0;
      next_lo_cnt = 8'h00;
      // An if, not a ternary, so the unknown first sample starts at one
      if (trig_q) begin
        next_hi_cnt = hi_cnt + {7'h00, hi_cnt != 8'hff};
      end else begin
        next_hi_cnt = 8'h01;
      end
    end else begin
      next_bit_cnt = bit_cnt + {3'h0, rise};
      next_lo_cnt = lo_cnt + {7'h00, bit_cnt == 4'h0 && lo_cnt != 8'hff};
    end
  end

  // Register the helper state
  always_ff @(posedge link_clk) begin
    strobe_q <= next_strobe_q;
    trig_q <= next_trig_q;
    bit_cnt <= next_bit_cnt;
    hi_cnt <= next_hi_cnt;
    lo_cnt <= next_lo_cnt;
    ser_sh <= next_ser_sh;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One clock; trigger high is the converter's own reset
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (trigger);

  chk_reset_level: assert property (disable iff (1'b0)
    trigger [*4] |-> result_valid && !bit_strobe) else $error("valid low in reset");
  chk_valid_busy: assert property (
    bit_strobe |-> result_valid) else $error("strobe after valid fell");
  chk_strobe_gap: assert property (
    $rose(bit_strobe) |=> !bit_strobe ##1 (bit_strobe || !result_valid))
    else $error("strobe spacing wrong");
  chk_bit_total: assert property (
    $fell(result_valid) |-> bit_cnt == 4'hb) else $error("bit count not eleven");
  chk_conv_time: assert property (
    $fell(trigger) |-> ##[22:40] $fell(result_valid)) else $error("conversion too long");
  chk_setup_span: assert property (
    $rose(bit_strobe) && bit_cnt == 4'h0 |-> lo_cnt >= hi_cnt && lo_cnt <= hi_cnt + 8'h06)
    else $error("setup span not tied to trigger width");
  chk_msb_pair: assert property (
    !result_valid |-> par_word[10] == !par_word[9]) else $error("msb copy not inverted");
  chk_ser_order: assert property (
    $fell(result_valid) |-> ser_sh[9:1] == par_word[8:0]) else $error("serial order wrong");
  chk_ser_tail: assert property (
    $fell(result_valid) |-> ser_sh[0] == !ser_sh[10]) else $error("serial tail wrong");
endmodule

/* tb/adc_conversion_sequencer_tb.sv */
// Self-checking bench: host and converter ends joined over one link
`timescale 1ns/1ps
module adc_conversion_sequencer_tb;
  logic clock = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic start = 1'b0;
  logic bipolar_mode = 1'b0;
  logic twos_comp_sel = 1'b0;
  logic [9:0] target = 10'h2c3;
  logic [9:0] trial_word;
  logic comp_decision;
  logic busy, par_ready, ser_ready, conv_late;
  logic [10:0] par_result, ser_result;
  int num_errors = 0;
  int check_count = 0;

  // Unrelated clocks: 25 ns host, 160 ns converter
  always #12.5 clock = ~clock;
  always #80 link_clk = ~link_clk;

  // Comparator keeps a trial bit while the trial stays at or below the target
  assign comp_decision = (trial_word <= target);

  ////////////////////////////////////////////////////////////////////////////
  adcs_link_if link_bus ();

  adcs_device #(.EXT_TEMP(1'b0)) u_adcs_device (
    .link_clk(link_clk), .link(link_bus), .comp_decision(comp_decision),
    .trial_word(trial_word), .bipolar_mode(bipolar_mode),
    .twos_comp_sel(twos_comp_sel), .conv_late(conv_late)
  );

  // Long trigger hold, else the slow converter clock misses the pulse
  adcs_host #(.TRIG_HOLD(16), .STROBE_DLY(adcs_pkg::STROBE_DLY_CYC)) u_adcs_host (
    .clock(clock), .sys_rst(sys_rst), .link(link_bus), .start(start), .busy(busy),
    .par_result(par_result), .par_ready(par_ready), .ser_result(ser_result),
    .ser_ready(ser_ready)
  );

  adcs_link_monitor u_adcs_link_monitor (
    .link_clk(link_clk), .trigger(link_bus.trigger), .result_valid(link_bus.result_valid),
    .par_word(link_bus.par_word), .ser_data(link_bus.ser_data),
    .bit_strobe(link_bus.bit_strobe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared compare
  task automatic check(input logic [10:0] got, input logic [10:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits for the next capture; serial word is caught on its one-cycle pulse
  task automatic wait_result(input logic [9:0] code, input logic twos);
    int n;
    logic [10:0] ser_got;
    n = 0;
    ser_got = 11'h000;
    do begin
      @(posedge clock);
      #1;
      n++;
      if (ser_ready === 1'b1) begin
        ser_got = ser_result;
      end
    end while (par_ready !== 1'b1 && n < 400);
    check({10'h000, par_ready}, 11'h001);
    check({10'h000, busy}, 11'h000);
    check(par_result, twos ? {code[9], ~code[9], code[8:0]} : {~code[9], code});
    check(ser_got, {code, ~code[9]});
    // At a 160 ns link clock the 22 strobe halves alone outlast 800 ns
    check({10'h000, conv_late}, 11'h001);
  endtask

  // Straps set first, then one start pulse
  task automatic run_conv(input logic [9:0] code, input logic [1:0] mode);
    @(posedge clock);
    target <= code;
    bipolar_mode <= mode[0];
    twos_comp_sel <= mode[1];
    // Straps cross two converter flops; give them time to land
    repeat (16) @(posedge clock);
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    wait_result(code, mode == 2'h3);
  endtask

  // Reset for 8 edges, then the automatic conversion that follows
  task automatic reset_and_check(input logic [9:0] code);
    int n;
    n = 0;
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (7) @(posedge clock);
    #1;
    check({9'h000, link_bus.trigger, busy}, 11'h003);
    @(posedge clock);
    sys_rst <= 1'b0;
    while (link_bus.trigger !== 1'b0 && n < 100) begin
      @(posedge clock);
      #1;
      n++;
    end
    check({10'h000, link_bus.result_valid}, 11'h001);
    wait_result(code, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    reset_and_check(10'h2c3);
  endtask

  // Every coding mode, including twos select without bipolar, at edge codes
  task automatic test_coding();
    logic [9:0] codes [5] = '{10'h000, 10'h3ff, 10'h200, 10'h1ff, 10'h155};
    logic [1:0] modes [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    foreach (modes[m]) begin
      foreach (codes[c]) begin
        run_conv(codes[c], modes[m]);
      end
    end
  endtask

  // Start held high: the host retriggers only after each capture
  task automatic test_back_to_back();
    run_conv(10'h0f0, 2'h0);
    @(posedge clock);
    start <= 1'b1;
    wait_result(10'h0f0, 1'b0);
    wait_result(10'h0f0, 1'b0);
    @(posedge clock);
    start <= 1'b0;
  endtask

  // Reset lands in mid-conversion; the next result must still be whole
  task automatic test_abort();
    repeat (60) @(posedge clock);
    reset_and_check(10'h0f0);
  endtask

  task automatic wrap_up();
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    test_reset();
    test_coding();
    test_back_to_back();
    test_abort();
    wrap_up();
  end

  // Watchdog, well past the roughly 5300 cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    wrap_up();
  end
endmodule
